/* logic/status_event_reporter.sv */
// Status byte, event store, service request and serial report logic
`timescale 1ns/1ps
`include "ser_defs.svh"
module status_event_reporter
  import ser_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     srst_i,
  input  wire apb_req_t apb_i,
  output apb_rsp_t      apb_o,
  input  wire logic     poll_i,
  input  wire logic     cmd_busy_i,
  input  wire logic     selftest_done_i,
  input  wire logic     selftest_fail_i,
  input  wire logic     tx_ready_i,
  output logic          srq_o,
  output logic [7:0]    stb_o,
  output logic          stb_valid_o,
  output logic          tx_valid_o,
  output logic [7:0]    tx_data_o,
  output logic          selftest_run_o,
  output logic          normal_op_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // Code to store index, severity order built into the index layout
  function automatic logic [5:0] code_to_idx(input logic [9:0] c);
    logic [5:0] r;
    r = `EV_NONE;
    if (c == `CODE_INTERNAL) r = `IDX_INTERNAL;
    else if (c == 10'h0c9) r = 6'h01;
    else if (c == 10'h0cb) r = 6'h02;
    else if (c == 10'h0cd) r = 6'h03;
    else if (c == 10'h0ce) r = 6'h04;
    else if (c >= 10'h0fb && c <= 10'h100) r = 6'(c - 10'h0fb) + 6'h05;
    else if (c >= 10'h102 && c <= 10'h107) r = 6'(c - 10'h102) + 6'h0b;
    else if (c >= 10'h065 && c <= 10'h06d) r = 6'(c - 10'h065) + 6'h11;
    else if (c >= 10'h097 && c <= 10'h09b) r = 6'(c - 10'h097) + 6'h1a;
    else if (c >= 10'h227 && c <= 10'h22e) r = 6'(c - 10'h227) + 6'h1f;
    else if (c == 10'h191) r = `IDX_PWRON;
    else if (c >= 10'h1c3 && c <= 10'h1c8) r = 6'(c - 10'h1c3) + 6'h28;
    return r;
  endfunction

  function automatic logic [9:0] idx_to_code(input logic [5:0] i);
    logic [9:0] r;
    r = `CODE_NONE;
    if (i == `IDX_INTERNAL) r = `CODE_INTERNAL;
    else if (i == 6'h01) r = 10'h0c9;
    else if (i == 6'h02) r = 10'h0cb;
    else if (i == 6'h03) r = 10'h0cd;
    else if (i == 6'h04) r = 10'h0ce;
    else if (i <= 6'h0a) r = 10'(i - 6'h05) + 10'h0fb;
    else if (i <= `IDX_EXEC_HI) r = 10'(i - 6'h0b) + 10'h102;
    else if (i <= 6'h19) r = 10'(i - 6'h11) + 10'h065;
    else if (i <= `IDX_CMD_HI) r = 10'(i - 6'h1a) + 10'h097;
    else if (i <= `IDX_WARN_HI) r = 10'(i - 6'h1f) + 10'h227;
    else if (i == `IDX_PWRON) r = 10'h191;
    else if (i <= `IDX_SYS_HI) r = 10'(i - 6'h28) + 10'h1c3;
    return r;
  endfunction

  // Status byte of an index; bit 7 zero, bit 6 request, bit 5 error, bit 4 busy
  function automatic logic [7:0] stb_of(input logic [5:0] i, input logic inh,
                                        input logic busy);
    logic       rqs;
    logic [7:0] r;
    rqs = ~inh;
    r   = {3'b000, busy, 4'h0};
    if (i == `IDX_INTERNAL) r = {1'b0, rqs, 1'b1, busy, `NIB_INT};
    else if (i <= `IDX_EXEC_HI) r = {1'b0, rqs, 1'b1, busy, `NIB_EXEC};
    else if (i <= `IDX_CMD_HI) r = {1'b0, rqs, 1'b1, busy, `NIB_CMD};
    else if (i <= `IDX_WARN_HI) r = {1'b0, rqs, 1'b1, busy, `NIB_WARN};
    else if (i == `IDX_PWRON) r = {1'b0, rqs, 1'b0, busy, `NIB_PWRON};
    else if (i <= `IDX_COMM_HI) r = {1'b0, rqs, 1'b1, busy, `NIB_EXEC};
    else if (i <= `IDX_SYS_HI) r = {1'b0, rqs, 1'b0, busy, `NIB_OPC};
    return r;
  endfunction

  logic [`EV_NUM-1:0] pend_ff;
  logic [`EV_NUM-1:0] nxt_pend;
  logic [`EV_NUM-1:0] set_vec;
  logic [`EV_NUM-1:0] clr_vec;
  logic [5:0]         top_idx;
  logic [5:0]         sel_idx;
  logic               inhibit_ff;
  logic               serial_ff;
  init_state_t        state_ff;
  init_state_t        nxt_state;
  logic               poll_s1_ff;
  logic               poll_s2_ff;
  logic               poll_s3_ff;
  logic               poll_edge;
  logic [5:0]         q_idx_ff;
  logic [5:0]         tx_idx_ff;
  logic [7:0]         char_ff;
  logic               wr_acc;
  logic               rd_acc;
  logic               setup;
  logic               post_wr;
  logic               cmd_wr;
  logic               dcl;
  logic               reinit;
  logic               llo;
  logic               test_end;
  logic               tx_take;
  logic               any_nxt;
  logic [5:0]         post_idx;
  logic               mapped;

  assign setup    = apb_i.psel & ~apb_i.penable;
  assign wr_acc   = apb_i.psel & apb_i.penable & apb_o.pready & apb_i.pwrite;
  assign rd_acc   = apb_i.psel & apb_i.penable & apb_o.pready & ~apb_i.pwrite;
  assign post_wr  = wr_acc & (apb_i.paddr == `SER_OFF_POST);
  assign cmd_wr   = wr_acc & (apb_i.paddr == `SER_OFF_CMD);
  assign dcl      = cmd_wr & apb_i.pwdata[`CMD_DCL];
  assign reinit   = cmd_wr & apb_i.pwdata[`CMD_REINIT];
  assign llo      = cmd_wr & apb_i.pwdata[`CMD_LLO];
  assign post_idx = code_to_idx(apb_i.pwdata[9:0]);
  assign test_end = (state_ff == ST_TEST) & selftest_done_i;
  assign tx_take  = tx_valid_o & tx_ready_i;
  assign mapped   = (apb_i.paddr == `SER_OFF_CTRL) | (apb_i.paddr == `SER_OFF_POST)
                  | (apb_i.paddr == `SER_OFF_QUERY) | (apb_i.paddr == `SER_OFF_STATUS)
                  | (apb_i.paddr == `SER_OFF_CMD) | (apb_i.paddr == `SER_OFF_CHAR);

  // Poll strobe comes off the bus pins; edge taken after the second stage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      poll_s1_ff <= 1'b0;
      poll_s2_ff <= 1'b0;
      poll_s3_ff <= 1'b0;
    end else begin
      poll_s1_ff <= poll_i;
      poll_s2_ff <= poll_s1_ff;
      poll_s3_ff <= poll_s2_ff;
    end
  end
  assign poll_edge = poll_s2_ff & ~poll_s3_ff;

  // Lowest index wins, so the layout itself is the severity order
  always_comb begin
    top_idx = `EV_NONE;
    for (int k = `EV_NUM - 1; k >= 0; k--) begin
      if (pend_ff[k]) top_idx = 6'(k);
    end
    sel_idx = top_idx;
    if (inhibit_ff) sel_idx = pend_ff[`IDX_PWRON] ? `IDX_PWRON : `EV_NONE;
  end

  always_comb begin
    set_vec = '0;
    clr_vec = '0;
    if (post_wr && post_idx != `EV_NONE) set_vec[post_idx] = 1'b1;
    if (llo) set_vec[code_to_idx(`CODE_LLO)] = 1'b1;
    if (test_end) set_vec[`IDX_PWRON] = 1'b1;
    if (rd_acc && apb_i.paddr == `SER_OFF_QUERY && q_idx_ff != `EV_NONE)
      clr_vec[q_idx_ff] = 1'b1;
    if (poll_edge && !serial_ff && sel_idx != `EV_NONE)
      clr_vec[sel_idx] = 1'b1;
    if (tx_take && tx_idx_ff != `EV_NONE) clr_vec[tx_idx_ff] = 1'b1;
    if (dcl) clr_vec = clr_vec | ~(`EV_NUM'(1) << `IDX_PWRON);
    if (reinit) clr_vec = '1;
    // New events beat a clear landing in the same cycle
    nxt_pend = (pend_ff & ~clr_vec) | set_vec;
    any_nxt  = inhibit_ff ? nxt_pend[`IDX_PWRON] : (|nxt_pend);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) pend_ff <= `PEND_RESET;
    else pend_ff <= nxt_pend;
  end

  // Reinitialise sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_NORMAL: if (reinit) nxt_state = ST_TEST;
      ST_TEST: begin
        if (test_end) nxt_state = selftest_fail_i ? ST_HALT : ST_NORMAL;
      end
      ST_HALT: if (reinit) nxt_state = ST_TEST;
      default: nxt_state = ST_NORMAL;
    endcase
    if (reinit) nxt_state = ST_TEST;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff       <= ST_NORMAL;
      normal_op_o    <= 1'b1;
      selftest_run_o <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      normal_op_o    <= (nxt_state == ST_NORMAL);
      selftest_run_o <= (nxt_state == ST_TEST);
    end
  end

  // Control register; power-up state re-enables service requests
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      inhibit_ff <= 1'b0;
      serial_ff  <= 1'b0;
    end else if (reinit) begin
      inhibit_ff <= 1'b0;
    end else if (wr_acc && apb_i.paddr == `SER_OFF_CTRL) begin
      inhibit_ff <= apb_i.pwdata[`CTRL_INHIBIT];
      serial_ff  <= apb_i.pwdata[`CTRL_SERIAL];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) char_ff <= `CHAR_SPACE;
    else if (wr_acc && apb_i.paddr == `SER_OFF_CHAR) begin
      if (apb_i.pwdata[7:0] >= `CHAR_LO && apb_i.pwdata[7:0] <= `CHAR_HI)
        char_ff <= apb_i.pwdata[7:0];
      else char_ff <= `CHAR_SPACE;
    end
  end

  // Parallel bus: poll answer and service request line
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stb_o       <= 8'h00;
      stb_valid_o <= 1'b0;
      srq_o       <= 1'b0;
    end else begin
      stb_valid_o <= poll_edge & ~serial_ff;
      if (poll_edge && !serial_ff)
        stb_o <= stb_of(sel_idx, inhibit_ff, cmd_busy_i);
      // Drop for one cycle after a poll, so the rest gets a fresh request
      srq_o <= ~serial_ff & any_nxt & ~poll_edge;
    end
  end

  // Serial link: byte goes out unprompted, event cleared on acceptance
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
      tx_idx_ff  <= `EV_NONE;
    end else if (tx_take || reinit || dcl) begin
      tx_valid_o <= 1'b0;
      tx_idx_ff  <= `EV_NONE;
    end else if (!tx_valid_o && serial_ff && sel_idx != `EV_NONE) begin
      tx_valid_o <= 1'b1;
      tx_data_o  <= stb_of(sel_idx, inhibit_ff, cmd_busy_i);
      tx_idx_ff  <= sel_idx;
    end
  end

  // APB slave; data sampled in setup, answered in the first access cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      apb_o    <= '0;
      q_idx_ff <= `EV_NONE;
    end else begin
      apb_o.pready  <= setup;
      apb_o.pslverr <= setup & ~mapped;
      if (setup) begin
        q_idx_ff     <= top_idx;
        apb_o.prdata <= 32'h0000_0000;
        case (apb_i.paddr)
          `SER_OFF_CTRL:   apb_o.prdata <= {30'h0, serial_ff, inhibit_ff};
          `SER_OFF_QUERY:  apb_o.prdata <= {22'h0, idx_to_code(top_idx)};
          // Inhibited events still show here, with the request bit low
          `SER_OFF_STATUS: apb_o.prdata <= {19'h0, srq_o, state_ff, |pend_ff,
                                            stb_of(top_idx, inhibit_ff, cmd_busy_i)};
          `SER_OFF_CHAR:   apb_o.prdata <= {24'h0, char_ff};
          default:         apb_o.prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  sequence s_poll;
    poll_edge && !serial_ff && $countones(pend_ff) > 1 && !inhibit_ff && !cmd_wr;
  endsequence
  sequence s_gap_then_srq;
    !srq_o ##1 srq_o;
  endsequence
  sequence s_test_end_ok;
    state_ff == ST_TEST && selftest_done_i && !selftest_fail_i && !reinit;
  endsequence

  property p_reinit;
    reinit |=> selftest_run_o && !normal_op_o && pend_ff == '0;
  endproperty
  a_reinit: assert property (p_reinit) else $error("reinit did not restart");

  property p_pass;
    s_test_end_ok |=> normal_op_o && pend_ff[`IDX_PWRON];
  endproperty
  a_pass: assert property (p_pass) else $error("pass did not report 65");

  property p_fail;
    state_ff == ST_TEST && selftest_done_i && selftest_fail_i && !reinit
      |=> !normal_op_o && pend_ff[`IDX_PWRON] ##1 !normal_op_o;
  endproperty
  a_fail: assert property (p_fail) else $error("fail entered normal");

  property p_poll;
    s_poll |=> stb_valid_o && stb_o[5:0] != 6'h00 && stb_o[6];
  endproperty
  a_poll: assert property (p_poll) else $error("poll gave no byte");

  property p_busy;
    stb_valid_o |-> stb_o[4] == $past(cmd_busy_i);
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit wrong");

  property p_reraise;
    s_poll |=> s_gap_then_srq;
  endproperty
  a_reraise: assert property (p_reraise) else $error("no further request");

  property p_dcl;
    dcl && !llo && !reinit |=> (pend_ff & ~(`EV_NUM'(1) << `IDX_PWRON)) == '0;
  endproperty
  a_dcl: assert property (p_dcl) else $error("clear kept events");

  property p_inhibit;
    inhibit_ff && $past(inhibit_ff) && !pend_ff[`IDX_PWRON]
      && !$past(pend_ff[`IDX_PWRON]) |-> !srq_o;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("request not inhibited");

  property p_serial;
    serial_ff && !tx_valid_o && sel_idx != `EV_NONE && !reinit && !dcl |=> tx_valid_o;
  endproperty
  a_serial: assert property (p_serial) else $error("byte not sent");

  property p_rqs;
    stb_valid_o && stb_o[3:0] != 4'h0 |-> stb_o[6] == !$past(inhibit_ff);
  endproperty
  a_rqs: assert property (p_rqs) else $error("request bit wrong");

  property p_tx_hold;
    tx_valid_o && !tx_ready_i && !reinit && !dcl |=> tx_valid_o && $stable(tx_data_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("serial byte dropped");

  property p_sent_clear;
    tx_valid_o && tx_ready_i && !post_wr && !llo && !test_end |=> !pend_ff[$past(tx_idx_ff)];
  endproperty
  a_sent_clear: assert property (p_sent_clear) else $error("sent event kept");

  property p_quiet_byte;
    stb_valid_o && $past(inhibit_ff) && !$past(pend_ff[`IDX_PWRON]) |-> stb_o[7:5] == 3'b000
      && stb_o[3:0] == 4'h0;
  endproperty
  a_quiet_byte: assert property (p_quiet_byte) else $error("inhibited poll reported");

endmodule

/* include/ser_defs.svh */
// Offsets, field positions, codes and constants of the status event reporter
`ifndef SER_DEFS_SVH
`define SER_DEFS_SVH
`define SER_OFF_CTRL     8'h00
`define SER_OFF_POST     8'h04
`define SER_OFF_QUERY    8'h08
`define SER_OFF_STATUS   8'h0c
`define SER_OFF_CMD      8'h10
`define SER_OFF_CHAR     8'h14
`define CTRL_INHIBIT     0
`define CTRL_SERIAL      1
`define CMD_DCL          0
`define CMD_REINIT       1
`define CMD_LLO          2
`define EV_NUM           46
`define EV_NONE          6'h2e
`define IDX_INTERNAL     6'h00
`define IDX_EXEC_HI      6'h10
`define IDX_CMD_HI       6'h1e
`define IDX_WARN_HI      6'h26
`define IDX_PWRON        6'h27
`define IDX_COMM_HI      6'h2a
`define IDX_SYS_HI       6'h2d
`define NIB_CMD          4'h1
`define NIB_EXEC         4'h2
`define NIB_INT          4'h3
`define NIB_WARN         4'h5
`define NIB_PWRON        4'h1
`define NIB_OPC          4'h2
`define CODE_NONE        10'h000
`define CODE_INTERNAL    10'h15f
`define CODE_LLO         10'h0fb
`define CHAR_LO          8'h20
`define CHAR_HI          8'h7e
`define CHAR_SPACE       8'h20
`define PEND_RESET       46'h00_8000_0000_00
`endif

/* include/ser_pkg.sv */
// Types shared by the status event reporter
package ser_pkg;
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_TEST   = 3'b010,
    ST_HALT   = 3'b100
  } init_state_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
endpackage

/* tb/remote_host.sv */
// Remote controller model: serial poll strobes and serial link receiver
`timescale 1ns/1ps
module remote_host (
  input  wire logic clk_i,
  input  wire logic tx_valid_i,
  output logic      poll_o,
  output logic      tx_ready_o
);
  integer seed = 32'hba39;
  initial begin
    poll_o     = 1'b0;
    tx_ready_o = 1'b0;
  end
  // Random stalls, so a held byte must survive several cycles
  always @(posedge clk_i) begin
    tx_ready_o <= (($random(seed) & 3) == 0);
  end
  // Poll strobe long enough for the synchroniser, then a low gap
  task automatic serial_poll();
    @(posedge clk_i);
    poll_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    poll_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the status event reporter
`timescale 1ns/1ps
`include "ser_defs.svh"
module tb_top
  import ser_pkg::*;
  ;
  typedef struct packed {
    logic        err;
    logic [31:0] mask;
    logic [31:0] val;
  } note_t;
  logic        clk_i, srst_i, poll_i, cmd_busy_i, selftest_done_i, selftest_fail_i, tx_ready_i;
  apb_req_t    apb_i;
  apb_rsp_t    apb_o;
  logic        srq_o, stb_valid_o, tx_valid_o, selftest_run_o, normal_op_o;
  logic [7:0]  stb_o, tx_data_o, ch;
  logic        busy;
  integer      seed = 32'hba39;
  integer      n_mismatch = 0;
  integer      tests_run = 0;
  int          n;
  note_t       rd_q[$];
  logic [7:0]  byte_q[$];
  logic [7:0]  tx_q[$];
  // Codes 101 155 201 263 351 551 558 451 453 454 456
  logic [9:0]  codes [11] = '{10'h065, 10'h09b, 10'h0c9, 10'h107, 10'h15f, 10'h227,
                              10'h22e, 10'h1c3, 10'h1c5, 10'h1c6, 10'h1c8};
  logic [7:0]  cats [11]  = '{8'h61, 8'h61, 8'h62, 8'h62, 8'h63, 8'h65, 8'h65, 8'h62,
                              8'h62, 8'h42, 8'h42};
  logic [9:0]  sev [4]    = '{10'h22e, 10'h09b, 10'h107, 10'h15f};
  logic [7:0]  sevb [4]   = '{8'h63, 8'h62, 8'h61, 8'h65};

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  status_event_reporter dut_u (
    .clk_i(clk_i), .srst_i(srst_i), .apb_i(apb_i), .apb_o(apb_o), .poll_i(poll_i),
    .cmd_busy_i(cmd_busy_i), .selftest_done_i(selftest_done_i),
    .selftest_fail_i(selftest_fail_i), .tx_ready_i(tx_ready_i), .srq_o(srq_o),
    .stb_o(stb_o), .stb_valid_o(stb_valid_o), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .selftest_run_o(selftest_run_o), .normal_op_o(normal_op_o)
  );
  remote_host host_u (
    .clk_i(clk_i), .tx_valid_i(tx_valid_o), .poll_o(poll_i), .tx_ready_o(tx_ready_i)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic expire();
    n_mismatch = n_mismatch + 1;
    conclude();
  endtask
  // One APB transfer; a gap cycle keeps each call free of double drives
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (apb_o.pready !== 1'b1 && k < 16);
    if (k >= 16) expire();
    apb_i <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m = 32'hffffffff, input logic e = 1'b0);
    rd_q.push_back('{e, m, v});
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [31:0] st(logic s, logic [2:0] q, logic p, logic [7:0] b);
    return {19'h0, s, q, p, b};
  endfunction

  // Results are compared against the oldest note as they appear
  always @(posedge clk_i) begin
    note_t nt;
    if (apb_i.psel && apb_i.penable && apb_o.pready === 1'b1 && !apb_i.pwrite) begin
      nt = rd_q.pop_front();
      check(apb_o.prdata & nt.mask, nt.val);
      check({31'h0, apb_o.pslverr}, {31'h0, nt.err});
    end
    if (stb_valid_o === 1'b1) check({24'h0, stb_o}, {24'h0, byte_q.pop_front()});
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
      check({24'h0, tx_data_o}, {24'h0, tx_q.pop_front()});
  end

  initial begin
    #2000000;
    expire();
  end

  initial begin
    apb_i = '0;
    srst_i = 1'b1;
    cmd_busy_i = 1'b0;
    selftest_done_i = 1'b0;
    selftest_fail_i = 1'b0;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(`SER_OFF_STATUS, st(1'b1, 3'b001, 1'b1, 8'h41));
    rd(`SER_OFF_QUERY, 32'h191, 32'h3ff);
    rd(`SER_OFF_QUERY, 32'h0, 32'h3ff);
    $display("test reset done");
    foreach (codes[i]) begin
      busy = 1'($random(seed));
      cmd_busy_i <= busy;
      wr(`SER_OFF_POST, {22'h0, codes[i]});
      rd(`SER_OFF_STATUS, st(1'b1, 3'b001, 1'b1, cats[i] | {3'h0, busy, 4'h0}));
      rd(`SER_OFF_QUERY, {22'h0, codes[i]}, 32'h3ff);
    end
    cmd_busy_i <= 1'b0;
    wr(`SER_OFF_POST, 32'h06e);
    rd(`SER_OFF_QUERY, 32'h0, 32'h3ff);
    $display("test categories done");
    foreach (sev[i]) wr(`SER_OFF_POST, {22'h0, sev[i]});
    repeat (2) @(posedge clk_i);
    foreach (sevb[i]) begin
      check({31'h0, srq_o}, 32'h1);
      byte_q.push_back(sevb[i]);
      host_u.serial_poll();
    end
    check({31'h0, srq_o}, 32'h0);
    $display("test poll done");
    wr(`SER_OFF_CTRL, 32'h1 << `CTRL_INHIBIT);
    wr(`SER_OFF_POST, 32'h0c9);
    repeat (2) @(posedge clk_i);
    check({31'h0, srq_o}, 32'h0);
    rd(`SER_OFF_STATUS, st(1'b0, 3'b001, 1'b1, 8'h22));
    byte_q.push_back(8'h00);
    host_u.serial_poll();
    rd(`SER_OFF_QUERY, 32'h0c9, 32'h3ff);
    wr(`SER_OFF_CTRL, 32'h0);
    $display("test inhibit done");
    for (int f = 1; f >= 0; f--) begin
      wr(`SER_OFF_POST, 32'h0c9);
      wr(`SER_OFF_CMD, 32'h1 << `CMD_REINIT);
      n = 0;
      while (selftest_run_o !== 1'b1 && n < 16) begin
        @(posedge clk_i);
        n++;
      end
      if (n >= 16) expire();
      rd(`SER_OFF_STATUS, st(1'b0, 3'b010, 1'b0, 8'h00));
      @(posedge clk_i);
      selftest_done_i <= 1'b1;
      selftest_fail_i <= f[0];
      @(posedge clk_i);
      selftest_done_i <= 1'b0;
      selftest_fail_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check({31'h0, normal_op_o}, {31'h0, ~f[0]});
      check({31'h0, selftest_run_o}, 32'h0);
      rd(`SER_OFF_STATUS, st(1'b1, f[0] ? 3'b100 : 3'b001, 1'b1, 8'h41));
    end
    $display("test reinit done");
    wr(`SER_OFF_POST, 32'h0c9);
    wr(`SER_OFF_POST, 32'h227);
    wr(`SER_OFF_CMD, 32'h1 << `CMD_DCL);
    rd(`SER_OFF_QUERY, 32'h191, 32'h3ff);
    rd(`SER_OFF_QUERY, 32'h0, 32'h3ff);
    wr(`SER_OFF_CMD, 32'h1 << `CMD_LLO);
    rd(`SER_OFF_QUERY, 32'h0fb, 32'h3ff);
    $display("test clear done");
    wr(`SER_OFF_CTRL, 32'h1 << `CTRL_SERIAL);
    // Posted most serious first, so any overlap keeps this order
    tx_q.push_back(8'h62);
    tx_q.push_back(8'h65);
    tx_q.push_back(8'h42);
    wr(`SER_OFF_POST, 32'h0c9);
    wr(`SER_OFF_POST, 32'h227);
    wr(`SER_OFF_POST, 32'h1c6);
    n = 0;
    while (tx_q.size() != 0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) expire();
    rd(`SER_OFF_QUERY, 32'h0, 32'h3ff);
    wr(`SER_OFF_CTRL, 32'h0);
    $display("test serial done");
    for (int i = 0; i < 10; i++) begin
      ch = (i == 0) ? 8'h1f : (i == 1) ? 8'h20 : (i == 2) ? 8'h7e : (i == 3) ? 8'h7f
         : 8'($random(seed));
      wr(`SER_OFF_CHAR, {24'h0, ch});
      rd(`SER_OFF_CHAR, {24'h0, (ch >= 8'h20 && ch <= 8'h7e) ? ch : 8'h20}, 32'hff);
    end
    rd(8'h18, 32'h0, 32'hffffffff, 1'b1);
    $display("test char and unmapped done");
    repeat (4) @(posedge clk_i);
    check(rd_q.size() + byte_q.size() + tx_q.size(), 32'h0);
    conclude();
  end
endmodule
